// file: rtl/fault_sup_pkg.sv
/*
 * Constants for the motor bridge fault supervisor: timing in nanoseconds,
 * derived cycle counts and counter widths.
 * Assumes a single 200 MHz clock.
 */
package fault_sup_pkg;
  // ****************************************************************
  // Clock and channel count
  // ****************************************************************
  localparam int CLK_MHZ          = 200;
  localparam int NUM_CH           = 4;

  // ****************************************************************
  // Times as printed, in ns
  // ****************************************************************
  localparam int OC_QUAL_NS       = 2000;
  localparam int RETRY_NS         = 128000;
  localparam int TRIAL_NS         = 2000;
  localparam int PS_LOW_NS        = 10000;
  localparam int SETTLE_NS        = 50000;

  // ****************************************************************
  // Cycle counts (least times round up)
  // ****************************************************************
  localparam int OC_QUAL_CYC      = (OC_QUAL_NS * CLK_MHZ + 999) / 1000;
  localparam int RETRY_CYC        = (RETRY_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIAL_CYC        = (TRIAL_NS * CLK_MHZ + 999) / 1000;
  localparam int PS_LOW_CYC       = (PS_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  localparam int CNT_W            = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

  typedef enum logic [1:0] {OC_IDLE, OC_RETRY, OC_TRIAL, OC_LATCHED} oc_state_type;
endpackage : fault_sup_pkg

// file: rtl/fault_sup.sv
/*
 * Fault supervisor for a quad H-bridge: undervoltage, overtemperature and
 * overcurrent gating of the bridge drive, with timed overcurrent retry.
 * Assumes analog monitors and host pins are asynchronous to clk.
 */
`timescale 1ns/1ps

module fault_sup
  import fault_sup_pkg::*;
(
  // Clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // Analog monitor indications
  input  wire logic                             undervoltage_in,
  input  wire logic                             supply_good_in,
  input  wire logic                             overtemp_in,
  input  wire logic                             oc_high_side_in,
  input  wire logic                             oc_low_side_in,
  // Host controls
  input  wire logic                             power_save_input,
  input  wire logic [fault_sup_pkg::NUM_CH-1:0] channel_enable_input,
  input  wire logic [fault_sup_pkg::NUM_CH-1:0] channel_dir_input,
  // Bridge drive
  output logic [fault_sup_pkg::NUM_CH-1:0]      bridge_on_q,
  output logic [fault_sup_pkg::NUM_CH-1:0]      bridge_dir_q,
  // Status
  output logic                                  undervoltage_shutdown_q,
  output logic                                  thermal_shutdown_q,
  output logic                                  overcurrent_protection_q
);
  import fault_sup_pkg::*;

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  localparam int NSYNC = 6 + 2 * NUM_CH;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  assign raw = {channel_dir_input, channel_enable_input, power_save_input,
                oc_low_side_in, oc_high_side_in, overtemp_in,
                supply_good_in, undervoltage_in};

  // Only the second stage is read by logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic              uv_s, good_s, ot_s, oc_s, ps_s;
  logic [NUM_CH-1:0] en_s, dir_s;
  assign uv_s   = s2_q[0];
  assign good_s = s2_q[1];
  assign ot_s   = s2_q[2];
  assign oc_s   = s2_q[3] | s2_q[4];
  assign ps_s   = s2_q[5];
  assign en_s   = s2_q[6 +: NUM_CH];
  assign dir_s  = s2_q[6+NUM_CH +: NUM_CH];

  // ****************************************************************
  // Undervoltage shutdown
  // ****************************************************************
  // Held until the supply-good indication returns and undervoltage lifts
  logic uv_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) uv_q <= 1'b1;
    else if (uv_s) uv_q <= 1'b1;
    else if (good_s) uv_q <= 1'b0;
  end

  // ****************************************************************
  // Regulator settle timer
  // ****************************************************************
  logic [CNT_W-1:0] settle_q;
  logic             ready_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q <= CNT_ZERO;
      ready_q  <= 1'b0;
    end else if (uv_q || !ps_s) begin
      settle_q <= CNT_ZERO;
      ready_q  <= 1'b0;
    end else if (!ready_q) begin
      if (settle_q == CNT_W'(SETTLE_CYC - 1)) ready_q <= 1'b1;
      else settle_q <= settle_q + 1'b1;
    end
  end

  // ****************************************************************
  // Overcurrent sequencer
  // ****************************************************************
  oc_state_type     oc_state_q;
  logic [CNT_W-1:0] qual_q;
  logic [CNT_W-1:0] tmr_q;
  logic [CNT_W-1:0] ps_low_q;
  logic             ps_pulse_ok_q;
  logic             qual_hit;
  assign qual_hit = oc_s && (qual_q == CNT_W'(OC_QUAL_CYC - 1));

  // Qualify counter runs only in idle; a trip in the trial latches at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) qual_q <= CNT_ZERO;
    else if (uv_q || !oc_s || oc_state_q != OC_IDLE) qual_q <= CNT_ZERO;
    else if (!qual_hit) qual_q <= qual_q + 1'b1;
  end

  // Power-save low-time measurement for the latch release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ps_low_q      <= CNT_ZERO;
      ps_pulse_ok_q <= 1'b0;
    end else if (uv_q || ps_s) begin
      ps_low_q      <= CNT_ZERO;
      // Held until power-save goes high: an old pulse must not release a later latch
      ps_pulse_ok_q <= 1'b0;
    end else if (ps_low_q == CNT_W'(PS_LOW_CYC - 1)) begin
      ps_pulse_ok_q <= 1'b1;
    end else begin
      ps_low_q <= ps_low_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      oc_state_q <= OC_IDLE;
      tmr_q      <= CNT_ZERO;
    end else if (uv_q) begin
      oc_state_q <= OC_IDLE;
      tmr_q      <= CNT_ZERO;
    end else begin
      case (oc_state_q)
        OC_IDLE: begin
          tmr_q <= CNT_ZERO;
          if (qual_hit) oc_state_q <= OC_RETRY;
        end
        OC_RETRY: begin
          if (tmr_q == CNT_W'(RETRY_CYC - 1)) begin
            tmr_q      <= CNT_ZERO;
            oc_state_q <= OC_TRIAL;
          end else tmr_q <= tmr_q + 1'b1;
        end
        OC_TRIAL: begin
          if (oc_s) oc_state_q <= OC_LATCHED;
          else if (tmr_q == CNT_W'(TRIAL_CYC - 1)) oc_state_q <= OC_IDLE;
          else tmr_q <= tmr_q + 1'b1;
        end
        OC_LATCHED: begin
          // Release needs high after a qualified low, with the trip gone
          if (ps_s && ps_pulse_ok_q && !oc_s) oc_state_q <= OC_IDLE;
        end
        default: oc_state_q <= OC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Output gating
  // ****************************************************************
  // Off under undervoltage, overtemp, retry, latch or a qualify hit; a trip in the trial gates one cycle late; thermal release needs no latch clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bridge_on_q              <= '0;
      bridge_dir_q             <= '0;
      undervoltage_shutdown_q  <= 1'b1;
      thermal_shutdown_q       <= 1'b0;
      overcurrent_protection_q <= 1'b0;
    end else begin
      undervoltage_shutdown_q  <= uv_q;
      thermal_shutdown_q       <= !uv_q && !uv_s && ot_s;
      overcurrent_protection_q <= !uv_q && !uv_s && !ot_s && (oc_state_q == OC_RETRY ||
                                  oc_state_q == OC_LATCHED);
      bridge_dir_q             <= dir_s;
      if (uv_q || uv_s) bridge_on_q <= '0;
      else if (ot_s) bridge_on_q <= '0;
      else if (oc_state_q == OC_RETRY || oc_state_q == OC_LATCHED || qual_hit)
        bridge_on_q <= '0;
      else if (ready_q) bridge_on_q <= en_s;
      else bridge_on_q <= '0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_uv_off;
    @(posedge clk) disable iff (rst) uv_q |=> (bridge_on_q == '0);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("on during undervoltage");

  property p_uv_clear;
    @(posedge clk) disable iff (rst) uv_q |=> oc_state_q == OC_IDLE || uv_q;
  endproperty
  a_uv_clear: assert property (p_uv_clear) else $error("oc state kept");

  property p_uv_recover;
    @(posedge clk) disable iff (rst) (uv_q && !uv_s && good_s) |=> !uv_q;
  endproperty
  a_uv_recover: assert property (p_uv_recover) else $error("no uv recovery");

  property p_ot_off;
    @(posedge clk) disable iff (rst) ot_s |=> (bridge_on_q == '0);
  endproperty
  a_ot_off: assert property (p_ot_off) else $error("on during overtemp");

  property p_ot_release;
    @(posedge clk) disable iff (rst)
      (!uv_q && !ot_s && ready_q && oc_state_q == OC_IDLE && !qual_hit)
      |=> bridge_on_q == $past(en_s);
  endproperty
  a_ot_release: assert property (p_ot_release) else $error("no follow");

  property p_qual;
    @(posedge clk) disable iff (rst)
      (oc_state_q == OC_IDLE && !uv_q && oc_s && qual_q == CNT_ZERO) ##0 oc_s [*8]
      |-> oc_state_q == OC_IDLE;
  endproperty
  a_qual: assert property (p_qual) else $error("trip too early");

  // Own count of the retry length, so the check does not reuse tmr_q
  logic [CNT_W-1:0] retry_len_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) retry_len_q <= CNT_ZERO;
    else if (oc_state_q == OC_RETRY) retry_len_q <= retry_len_q + 1'b1;
    else retry_len_q <= CNT_ZERO;
  end

  property p_trial;
    @(posedge clk) disable iff (rst)
      (oc_state_q == OC_RETRY && !uv_q)
      |=> (oc_state_q == OC_TRIAL) == (retry_len_q == CNT_W'(RETRY_CYC));
  endproperty
  a_trial: assert property (p_trial) else $error("retry length");

  property p_latch;
    @(posedge clk) disable iff (rst)
      (oc_state_q == OC_TRIAL && oc_s && !uv_q) |=> oc_state_q == OC_LATCHED;
  endproperty
  a_latch: assert property (p_latch) else $error("no latch");

  property p_release;
    @(posedge clk) disable iff (rst)
      (oc_state_q == OC_LATCHED && $past(oc_state_q) == OC_LATCHED && !uv_q
       && !(ps_s && ps_pulse_ok_q && !oc_s)) |=> oc_state_q == OC_LATCHED;
  endproperty
  a_release: assert property (p_release) else $error("latch dropped");

  property p_release_edge;
    @(posedge clk) disable iff (rst)
      (oc_state_q == OC_LATCHED && !uv_q) ##1 (oc_state_q == OC_IDLE)
      |-> $past(ps_s) && !$past(ps_s, 2);
  endproperty
  a_release_edge: assert property (p_release_edge) else $error("stale release");

  c_trip:   cover property (@(posedge clk) oc_state_q == OC_RETRY);
  c_latch:  cover property (@(posedge clk) oc_state_q == OC_LATCHED);
  c_clear:  cover property (@(posedge clk) oc_state_q == OC_LATCHED ##1 oc_state_q == OC_IDLE);
  c_thermal: cover property (@(posedge clk) thermal_shutdown_q);
endmodule : fault_sup

// file: dv/host_model.sv
/*
 * Host controller model: drives power-save, enables and directions.
 * Assumes the bench calls its tasks; changes land on falling edges.
 */
`timescale 1ns/1ps
module host_model
  import fault_sup_pkg::*;
(
  // Clock
  input  wire logic                        clk,
  // Host pins
  output logic                             power_save_input,
  output logic [fault_sup_pkg::NUM_CH-1:0] channel_enable_input,
  output logic [fault_sup_pkg::NUM_CH-1:0] channel_dir_input
);
  import fault_sup_pkg::*;

  initial begin
    power_save_input     = 1'b1;
    channel_enable_input = '0;
    channel_dir_input    = '0;
  end

  task automatic set_ch(input logic [NUM_CH-1:0] en, input logic [NUM_CH-1:0] dir);
    @(negedge clk);
    channel_enable_input = en;
    channel_dir_input    = dir;
  endtask : set_ch

  // Short counts are legal here so the bench can test a refused pulse
  task automatic pulse_ps(input int low_cyc);
    @(negedge clk);
    power_save_input = 1'b0;
    repeat (low_cyc) @(negedge clk);
    power_save_input = 1'b1;
  endtask : pulse_ps
endmodule : host_model

// file: dv/tb.sv
/*
 * Self-checking bench for the fault supervisor.
 * Assumes a 200 MHz clock and the host model beside it.
 */
`timescale 1ns/1ps
module tb;
  import fault_sup_pkg::*;
  // ****************
  // Stimulus and DUT
  // ****************
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              uv = 1'b0, good = 1'b1, ot = 1'b0, och = 1'b0, ocl = 1'b0;
  logic              ps, uvs, thermal_shutdown, overcurrent_protection;
  logic [NUM_CH-1:0] en, dir, on, odir;
  logic [31:0]       lfsr = 32'h100526F1;
  int                fail_count = 0;
  int                cmp_count = 0;
  always #2.5 clk = ~clk;

  host_model host_model_i (.clk(clk), .power_save_input(ps),
    .channel_enable_input(en), .channel_dir_input(dir));
  fault_sup fault_sup_i (.clk(clk), .rst(rst), .undervoltage_in(uv),
    .supply_good_in(good), .overtemp_in(ot), .oc_high_side_in(och),
    .oc_low_side_in(ocl), .power_save_input(ps), .channel_enable_input(en),
    .channel_dir_input(dir), .bridge_on_q(on), .bridge_dir_q(odir),
    .undervoltage_shutdown_q(uvs), .thermal_shutdown_q(thermal_shutdown),
    .overcurrent_protection_q(overcurrent_protection));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Any active fault blocks every channel
  function automatic logic [NUM_CH-1:0] exp_on(input logic [NUM_CH-1:0] e, input logic f);
    return f ? '0 : e;
  endfunction : exp_on

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wc(input int n);
    repeat (n) @(negedge clk);
  endtask : wc

  task automatic wait_ocp(input int bound);
    int k = 0;
    while (overcurrent_protection !== 1'b1 && k < bound) begin
      @(negedge clk);
      k++;
    end
    check(overcurrent_protection, 1'b1);
    if (k >= bound) tally_and_finish();
  endtask : wait_ocp

  initial begin
    wc(5);
    check(on, 4'h0);
    rst = 1'b0;
    host_model_i.set_ch(4'hF, 4'h5);
    wc(SETTLE_CYC - 100);
    check(on, 4'h0);
    check(uvs, 1'b0);
    wc(120);
    check(on, 4'hF);
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      host_model_i.set_ch(lfsr[3:0], lfsr[7:4]);
      ot = lfsr[8];
      wc(8);
      check(on, exp_on(lfsr[3:0], lfsr[8]));
      check(thermal_shutdown, lfsr[8]);
      check(odir, lfsr[7:4]);
    end
    ot = 1'b0;
    host_model_i.set_ch(4'hF, 4'hA);
    och = 1'b1;
    wc(OC_QUAL_CYC - 50);
    och = 1'b0;
    wc(8);
    check(on, 4'hF);
    ocl = 1'b1;
    wc(OC_QUAL_CYC - 10);
    check(on, 4'hF);
    wait_ocp(40);
    wc(2);
    check(on, 4'h0);
    ocl = 1'b0;
    wc(RETRY_CYC - 50);
    check(on, 4'h0);
    wc(60);
    check(on, 4'hF);
    wc(TRIAL_CYC + 10);
    check(overcurrent_protection, 1'b0);
    // Held overcurrent through the trial latches the fault
    och = 1'b1;
    wait_ocp(OC_QUAL_CYC + 40);
    wc(RETRY_CYC + TRIAL_CYC + 20);
    och = 1'b0;
    wc(RETRY_CYC + 100);
    check(overcurrent_protection, 1'b1);
    check(on, 4'h0);
    ot = 1'b1;
    wc(8);
    check(thermal_shutdown, 1'b1);
    check(overcurrent_protection, 1'b0);
    ot = 1'b0;
    wc(8);
    check(overcurrent_protection, 1'b1);
    host_model_i.pulse_ps(PS_LOW_CYC / 2);
    wc(8);
    check(overcurrent_protection, 1'b1);
    host_model_i.pulse_ps(PS_LOW_CYC + 10);
    wc(8);
    check(overcurrent_protection, 1'b0);
    ocl = 1'b1;
    wait_ocp(OC_QUAL_CYC + 40);
    ocl = 1'b0;
    uv = 1'b1;
    ot = 1'b1;
    wc(8);
    check(uvs, 1'b1);
    check(thermal_shutdown, 1'b0);
    check(on, 4'h0);
    uv = 1'b0;
    ot = 1'b0;
    good = 1'b0;
    wc(8);
    check(uvs, 1'b1);
    good = 1'b1;
    wc(8);
    check(uvs, 1'b0);
    check(overcurrent_protection, 1'b0);
    wc(SETTLE_CYC + 20);
    check(on, 4'hF);
    tally_and_finish();
  end
endmodule : tb
